// ---- inc/hbridge_pkg.sv ----
package hbridge_pkg;

  // system clock rate
  localparam int CLK_MHZ = 125;

  // internal oscillator, half period gives one output phase
  localparam int OSC_KHZ          = 425;
  localparam int OSC_HALF_CYC     = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
  localparam logic [8:0] OSC_HALF = 9'(OSC_HALF_CYC);

  // watchdog timeout, least time rounds up
  localparam int WDOG_US           = 20;
  localparam int WDOG_CYC          = WDOG_US * CLK_MHZ;
  localparam logic [11:0] WDOG_MAX = 12'(WDOG_CYC);

  // on-phase trim, longest time rounds down, at least one cycle
  localparam int TRIM_NS          = 10;
  localparam int TRIM_CYC_RAW     = (TRIM_NS * CLK_MHZ) / 1000;
  localparam int TRIM_CYC         = (TRIM_CYC_RAW < 1) ? 1 : TRIM_CYC_RAW;
  localparam logic [3:0] TRIM_MAX = 4'(TRIM_CYC);

  // dead interval between phases
  localparam int DEAD_NS          = 30;
  localparam int DEAD_CYC         = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DEAD_MAX = 4'(DEAD_CYC);

  // blanking and autoretry in microseconds, counts in cycles
  localparam int BLANK_US = 1200;
  localparam int RETRY_US = 38400;
  localparam int BLANK_CYC_DEF = BLANK_US * CLK_MHZ;
  localparam int RETRY_CYC_DEF = RETRY_US * CLK_MHZ;

  // drive phases of the bridge
  typedef enum logic [3:0] {
    PH_A    = 4'h1,
    PH_DEADA = 4'h2,
    PH_B    = 4'h4,
    PH_DEADB = 4'h8
  } phase_t;

  // protection states
  typedef enum logic [3:0] {
    PR_RUN   = 4'h1,
    PR_OC    = 4'h2,
    PR_THERM = 4'h4,
    PR_OFF   = 4'h8
  } prot_t;

  // drive pins as one carrier
  typedef struct packed {
    logic driveA;
    logic driveAOe;
    logic driveB;
    logic driveBOe;
    logic faultOe;
  } pins_t;

endpackage

// ---- core/hbridge_clock_fault_ctrl.sv ----
`timescale 1ns/10ps
module hbridge_clock_fault_ctrl #(
  parameter int BLANK_CYC = hbridge_pkg::BLANK_CYC_DEF,
  parameter int RETRY_CYC = hbridge_pkg::RETRY_CYC_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic extClk,
  input  wire logic enable_n,
  input  wire logic supplyLow,
  input  wire logic overCurrent,
  input  wire logic tempHigh,
  input  wire logic tempLow,
  output logic      driveA,
  output logic      driveAOe,
  output logic      driveB,
  output logic      driveBOe,
  output logic      faultOe,
  output logic      lowPower,
  output logic      extMode
);

  typedef struct packed {
    logic [1:0]          ocSync;
    logic [1:0]          thSync;
    logic [1:0]          tlSync;
    logic                clkPrev;
    logic [11:0]         wdog;
    logic                ext;
    logic [8:0]          osc;
    logic                toggle;
    hbridge_pkg::phase_t phase;
    logic [3:0]          dead;
    logic [3:0]          trim;
    hbridge_pkg::prot_t  prot;
    logic [31:0]         timer;
    hbridge_pkg::pins_t  pins;
    logic                lowPower;
  } state_t;

  state_t st;
  state_t next_st;

  logic ocS;
  logic thS;
  logic tlS;
  logic clkRise;
  logic stepReq;

  assign ocS = st.ocSync[1];
  assign thS = st.thSync[1];
  assign tlS = st.tlSync[1];
  assign clkRise = extClk && !st.clkPrev;

  // whole next-state function; toggle source picks the phase step
  always_comb begin
    next_st = st;
    next_st.ocSync = {st.ocSync[0], overCurrent};
    next_st.thSync = {st.thSync[0], tempHigh};
    next_st.tlSync = {st.tlSync[0], tempLow};
    next_st.clkPrev = extClk;
    if (clkRise) begin
      next_st.wdog = '0;
      next_st.ext  = 1'b1; // applied clock selects external
    end else if (st.wdog >= hbridge_pkg::WDOG_MAX) begin
      next_st.ext = 1'b0; // stalled or grounded input: internal
    end else begin
      next_st.wdog = st.wdog + 12'h001;
    end
    if (st.osc >= hbridge_pkg::OSC_HALF - 9'h001) begin
      next_st.osc = '0;
    end else begin
      next_st.osc = st.osc + 9'h001;
    end
    // one phase per rising edge (external) or oscillator wrap
    stepReq = st.ext ? clkRise : (st.osc == '0);
    if (stepReq) begin
      next_st.toggle = !st.toggle;
    end

    // protection sequencing
    case (st.prot)
      hbridge_pkg::PR_RUN: begin
        // lockout or enable high forces disable
        if (supplyLow || enable_n) begin
          next_st.prot = hbridge_pkg::PR_OFF;
        end else if (thS) begin
          next_st.prot = hbridge_pkg::PR_THERM;
        end else if (ocS) begin
          if (st.timer >= 32'(BLANK_CYC - 1)) begin
            next_st.prot  = hbridge_pkg::PR_OC;
            next_st.timer = '0;
          end else begin
            next_st.timer = st.timer + 32'h1;
          end
        end else begin
          next_st.timer = '0;
        end
      end
      hbridge_pkg::PR_OC: begin
        if (supplyLow || enable_n) begin
          next_st.prot = hbridge_pkg::PR_OFF;
        end else if (st.timer >= 32'(RETRY_CYC - 1)) begin
          next_st.prot  = hbridge_pkg::PR_RUN;
          next_st.timer = '0;
        end else begin
          next_st.timer = st.timer + 32'h1;
        end
      end
      hbridge_pkg::PR_THERM: begin
        // resume only once below lower threshold
        if (supplyLow || enable_n) begin
          next_st.prot = hbridge_pkg::PR_OFF;
        end else if (tlS) begin
          next_st.prot  = hbridge_pkg::PR_RUN;
          next_st.timer = '0;
        end
      end
      hbridge_pkg::PR_OFF: begin
        // leave disable once supply good and enabled
        if (!supplyLow && !enable_n) begin
          next_st.prot  = hbridge_pkg::PR_RUN;
          next_st.timer = '0;
        end
      end
      default: next_st.prot = hbridge_pkg::PR_OFF;
    endcase

    // bridge phase sequencer
    case (st.phase)
      hbridge_pkg::PH_A: begin
        if (st.toggle == 1'b0) begin
          next_st.phase = hbridge_pkg::PH_DEADA;
          next_st.dead  = '0;
          next_st.trim  = '0;
        end
      end
      hbridge_pkg::PH_DEADA: begin
        // trim extends the gap, shortening the on-phase
        if (st.trim < hbridge_pkg::TRIM_MAX) begin
          next_st.trim = st.trim + 4'h1;
        // dead interval before the other pair
        end else if (st.dead >= hbridge_pkg::DEAD_MAX - 4'h1) begin
          next_st.phase = hbridge_pkg::PH_B;
        end else begin
          next_st.dead = st.dead + 4'h1;
        end
      end
      hbridge_pkg::PH_B: begin
        if (st.toggle == 1'b1) begin
          next_st.phase = hbridge_pkg::PH_DEADB;
          next_st.dead  = '0;
          next_st.trim  = '0;
        end
      end
      hbridge_pkg::PH_DEADB: begin
        if (st.trim < hbridge_pkg::TRIM_MAX) begin
          next_st.trim = st.trim + 4'h1;
        end else if (st.dead >= hbridge_pkg::DEAD_MAX - 4'h1) begin
          next_st.phase = hbridge_pkg::PH_A;
        end else begin
          next_st.dead = st.dead + 4'h1;
        end
      end
      default: next_st.phase = hbridge_pkg::PH_DEADA;
    endcase

    // pins from next state so registered outputs line up with the state register, no extra delay
    next_st.pins.driveA   = (next_st.phase == hbridge_pkg::PH_A);
    next_st.pins.driveB   = (next_st.phase == hbridge_pkg::PH_B);
    next_st.pins.driveAOe = (next_st.prot == hbridge_pkg::PR_RUN)
                            && (next_st.phase == hbridge_pkg::PH_A
                                || next_st.phase == hbridge_pkg::PH_B);
    next_st.pins.driveBOe = next_st.pins.driveAOe;
    // fault pin pulled low only in fault-disabled states
    next_st.pins.faultOe  = (next_st.prot == hbridge_pkg::PR_OC)
                            || (next_st.prot == hbridge_pkg::PR_THERM);
    // low-current flag from next state, aligned with floating pins
    next_st.lowPower = (next_st.prot == hbridge_pkg::PR_OFF);
  end

  // state register; starts disabled and floating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ocSync: 2'h0, thSync: 2'h0, tlSync: 2'h0, clkPrev: 1'b0,
              wdog: 12'h000, ext: 1'b0, osc: 9'h000, toggle: 1'b0,
              phase: hbridge_pkg::PH_DEADA, dead: 4'h0, trim: 4'h0,
              prot: hbridge_pkg::PR_OFF, timer: 32'h0,
              pins: 5'h00, lowPower: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign driveA   = st.pins.driveA;
  assign driveAOe = st.pins.driveAOe;
  assign driveB   = st.pins.driveB;
  assign driveBOe = st.pins.driveBOe;
  assign faultOe  = st.pins.faultOe;
  assign lowPower = st.lowPower;
  assign extMode  = st.ext;

  property p_no_overlap;
    @(posedge clk) disable iff (!rst_n)
      !(driveAOe && driveA && driveB);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both phases on");

  // after A ends, floating for at least two cycles
  property p_gap;
    @(posedge clk) disable iff (!rst_n)
      $fell(st.phase == hbridge_pkg::PH_A) |-> !driveBOe [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("no dead gap");

  property p_off_float;
    @(posedge clk) disable iff (!rst_n)
      (st.prot == hbridge_pkg::PR_OFF) |-> !driveAOe && !driveBOe && lowPower;
  endproperty
  a_off_float: assert property (p_off_float) else $error("drive in off");

  // lockout leads to disable next cycle
  property p_lockout;
    @(posedge clk) disable iff (!rst_n)
      supplyLow |=> (st.prot == hbridge_pkg::PR_OFF);
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ignored");

  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      faultOe == (st.prot == hbridge_pkg::PR_OC || st.prot == hbridge_pkg::PR_THERM);
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin mismatch");

  // thermal shutdown from run within one cycle of synced flag
  property p_therm;
    @(posedge clk) disable iff (!rst_n)
      (st.prot == hbridge_pkg::PR_RUN && thS && !supplyLow && !enable_n)
        |=> faultOe && !driveAOe;
  endproperty
  a_therm: assert property (p_therm) else $error("no thermal stop");

  // thermal state held until lower threshold seen
  property p_hyst;
    @(posedge clk) disable iff (!rst_n)
      (st.prot == hbridge_pkg::PR_THERM && !tlS && !supplyLow && !enable_n)
        |=> (st.prot == hbridge_pkg::PR_THERM);
  endproperty
  a_hyst: assert property (p_hyst) else $error("early thermal exit");

  // external phase step only on rising edge
  property p_ext_step;
    @(posedge clk) disable iff (!rst_n)
      (st.ext && $changed(st.toggle)) |-> $past(clkRise);
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("step without edge");

  // stalled clock falls back to internal
  property p_wdog;
    @(posedge clk) disable iff (!rst_n)
      (st.wdog >= hbridge_pkg::WDOG_MAX && !clkRise) |=> !extMode;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog missed");

  property p_retry;
    @(posedge clk) disable iff (!rst_n)
      (st.prot == hbridge_pkg::PR_OC && st.timer >= 32'(RETRY_CYC - 1)
        && !supplyLow && !enable_n) |=> !faultOe;
  endproperty
  a_retry: assert property (p_retry) else $error("retry stuck");

endmodule

// ---- verification/transformer_primary.sv ----
`timescale 1ns/10ps
// primary winding seen by the bridge: flux integrator plus load current
module transformer_primary #(
  parameter int SAT_CYC = 4000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic driveA,
  input  wire logic driveAOe,
  input  wire logic driveB,
  input  wire logic driveBOe,
  input  wire logic overload,
  output logic      overCurrent
);
  int flux;
  // volt-seconds per phase; a stalled phase walks the core into saturation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flux <= 0;
    end else if (driveAOe && driveBOe && driveA != driveB) begin
      flux <= flux + (driveA ? 1 : -1);
    end
  end
  // current at limit
  // saturation looks like a heavy load to the current comparator
  assign overCurrent = overload || flux > SAT_CYC || flux < -SAT_CYC;
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  localparam int BLANK = 20;
  localparam int RETRY = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic extClk = 1'b0;
  logic enable_n = 1'b1;
  logic supplyLow = 1'b0;
  logic tempHigh = 1'b0;
  logic tempLow = 1'b1;
  logic overload = 1'b0;
  logic overCurrent;
  wire hbridge_pkg::pins_t pins;
  logic lowPower;
  logic extMode;
  int fail_count = 0;
  int num_checks = 0;
  int runA = 0, runB = 0, runG = 0, lenA = 0, lenB = 0, lenG = 0;
  int n, h, seedDummy;

  always #4 clk = ~clk;

  hbridge_clock_fault_ctrl #(.BLANK_CYC(BLANK), .RETRY_CYC(RETRY)) u_hbridge_clock_fault_ctrl (
    .clk(clk), .rst_n(rst_n), .extClk(extClk), .enable_n(enable_n), .supplyLow(supplyLow),
    .overCurrent(overCurrent), .tempHigh(tempHigh), .tempLow(tempLow),
    .driveA(pins.driveA), .driveAOe(pins.driveAOe), .driveB(pins.driveB),
    .driveBOe(pins.driveBOe), .faultOe(pins.faultOe), .lowPower(lowPower), .extMode(extMode));

  transformer_primary #(.SAT_CYC(4000)) u_transformer_primary (
    .clk(clk), .rst_n(rst_n), .driveA(pins.driveA), .driveAOe(pins.driveAOe),
    .driveB(pins.driveB), .driveBOe(pins.driveBOe), .overload(overload),
    .overCurrent(overCurrent));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bounded wait on fault (sel 0) or clock mode (sel 1); n counts cycles
  task automatic waitSig(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (((sel == 0) ? pins.faultOe : extMode) !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (((sel == 0) ? pins.faultOe : extMode) !== v) begin
      fail_count++;
      $display("[FAIL] %0t wait limit %h exp %h", $time, cnt, v);
      close_out();
    end
  endtask

  // run lengths of each on-phase and of the floating gap, settled values
  always @(negedge clk) begin
    if (pins.driveAOe === 1'b1) begin
      check(pins.driveA ^ pins.driveB, 32'h1);
      check(pins.driveBOe, 32'h1);
    end
    if (pins.faultOe === 1'b1) check(pins.driveAOe, 32'h0);
    if (pins.driveAOe === 1'b1 && pins.driveA === 1'b1) runA++;
    else if (runA != 0) begin lenA = runA; runA = 0; end
    if (pins.driveAOe === 1'b1 && pins.driveB === 1'b1) runB++;
    else if (runB != 0) begin lenB = runB; runB = 0; end
    if (pins.driveAOe !== 1'b1) runG++;
    else if (runG != 0) begin lenG = runG; runG = 0; end
  end

  initial begin
    seedDummy = $urandom(32'h3d457341);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(lowPower, 32'h1);
    check(pins.driveAOe, 32'h0);
    enable_n = 1'b0;
    repeat (1000) @(negedge clk);
    check(extMode, 32'h0);
    check(lenA, lenB);
    check(lenA + lenG, hbridge_pkg::OSC_HALF_CYC);
    check(lenG >= hbridge_pkg::TRIM_CYC + hbridge_pkg::DEAD_CYC, 32'h1);
    // applied clock, random half period of 8 to 27 cycles
    for (int k = 0; k < 2; k++) begin
      h = 8 + ($urandom % 20);
      for (int i = 0; i < 80; i++) begin
        repeat (h) @(negedge clk);
        extClk = ~extClk;
      end
      check(extMode, 32'h1);
      check(lenA, lenB);
      check(lenA + lenG, 2 * h);
    end
    waitSig(1, 1'b0, 3000, n);
    check(n + 2 * h + 8 >= hbridge_pkg::WDOG_CYC && n <= hbridge_pkg::WDOG_CYC + 8, 32'h1);
    repeat (1000) @(negedge clk);
    check(lenA + lenG, hbridge_pkg::OSC_HALF_CYC);
    // persistent overload: blank, retry, restart, blank again
    overload = 1'b1;
    waitSig(0, 1'b1, BLANK + 40, n);
    check(n >= BLANK, 32'h1);
    waitSig(0, 1'b0, RETRY + 40, n);
    check(n + 2 >= RETRY && n <= RETRY + 2, 32'h1);
    waitSig(0, 1'b1, BLANK + 40, n);
    check(n >= BLANK, 32'h1);
    overload = 1'b0;
    waitSig(0, 1'b0, RETRY + 40, n);
    repeat (200) @(negedge clk);
    check(pins.faultOe, 32'h0);
    // thermal episode with hysteresis
    tempHigh = 1'b1;
    tempLow = 1'b0;
    waitSig(0, 1'b1, 6, n);
    check(n, 32'h3);
    tempHigh = 1'b0;
    repeat (10 + ($urandom % 30)) @(negedge clk);
    check(pins.faultOe, 32'h1);
    tempLow = 1'b1;
    waitSig(0, 1'b0, 6, n);
    check(n, 32'h3);
    repeat (200) @(negedge clk);
    check({pins.faultOe, lowPower, pins.driveAOe === 1'b1 || runG > 0}, 32'h1);
    // lockout then enable high both float the bridge
    supplyLow = 1'b1;
    repeat (2) @(negedge clk);
    check(pins.driveAOe, 32'h0);
    check(lowPower, 32'h1);
    supplyLow = 1'b0;
    repeat (300) @(negedge clk);
    enable_n = 1'b1;
    repeat (2) @(negedge clk);
    check({pins.driveAOe, lowPower}, 32'h1);
    close_out();
  end
endmodule
